//--- include/wsc_pkg.sv
// package: constants, state and carrier types of the watchdog/sleep block
package wsc_pkg;

  // register indices (printed offsets); byte address is index times four
  localparam logic [15:0] WSC_IDX_OPTION = 16'h0081;
  localparam logic [15:0] WSC_IDX_CONFIG = 16'h2007;
  localparam logic [15:0] WSC_IDX_STATUS = 16'h0003;
  localparam logic [15:0] WSC_ADR_OPTION = {WSC_IDX_OPTION[13:0], 2'b00};
  localparam logic [15:0] WSC_ADR_CONFIG = {WSC_IDX_CONFIG[13:0], 2'b00};
  localparam logic [15:0] WSC_ADR_STATUS = {WSC_IDX_STATUS[13:0], 2'b00};

  // option register: reset value and watchdog fields
  localparam logic [7:0] WSC_OPT_RESET = 8'hFF;
  localparam int WSC_OPT_ASSIGN_BIT = 3;
  localparam int WSC_OPT_RATE_MSB  = 2;
  localparam int WSC_OPT_RATE_LSB  = 0;

  // configuration word fields
  localparam int WSC_CFG_WDT_EN_BIT = 2;
  localparam int WSC_CFG_OSC_BIT    = 0;

  // status register fields
  localparam int WSC_ST_PD_BIT    = 3;
  localparam int WSC_ST_TO_BIT    = 4;
  localparam int WSC_ST_ASLEEP_BIT = 0;

  // timing: pclk at 40 MHz
  localparam int WSC_CLK_MHZ       = 40;
  localparam int WSC_WDT_BASE_US   = 18000;
  localparam int WSC_WDT_BASE_CYC  = WSC_WDT_BASE_US * WSC_CLK_MHZ;
  localparam int WSC_OST_TOSC      = 1024;
  localparam int WSC_OST_CYC       = WSC_OST_TOSC;
  localparam logic [10:0] WSC_OST_LAST = 11'(WSC_OST_CYC - 1);

  // interrupt sources able to wake the core while asleep
  localparam logic [11:0] WSC_WAKE_MASK = 12'hDFE;

  typedef enum logic [2:0] {
    WSC_RUN    = 3'b000,
    WSC_SLEEP  = 3'b001,
    WSC_OST    = 3'b011,
    WSC_RESUME = 3'b010,
    WSC_DUMMY1 = 3'b110,
    WSC_DUMMY2 = 3'b111,
    WSC_VECTOR = 3'b101
  } wsc_state_e;

  typedef struct packed {
    logic        clr_wdt;
    logic        sleep;
    logic        global_irq_enable;
    logic [11:0] irq_flag;
    logic [11:0] irq_en;
  } wsc_core_in_s;

  typedef struct packed {
    logic dev_reset;
    logic osc_off;
    logic io_hold;
    logic core_stall;
    logic resume;
    logic dummy;
    logic vector;
  } wsc_core_out_s;

endpackage

//--- rtl/wsc_watchdog_sleep.sv
// watchdog timer and sleep/wake control with an APB register slave
//
// Function
// - watchdog counts on its own, even asleep
// - time-out while running resets the device
// - time-out while asleep wakes and resumes
// - cleared enable bit disables watchdog permanently
// - base time-out about eighteen milliseconds
// - prescaler assignable, rate up to 128
// - clear or sleep clears counter and prescaler
// - clear leaves prescaler assignment unchanged
// - after sleep, time-out wakes, never resets
// - time-out in run or sleep clears the time-out flag
// - sleep clears watchdog, pd, sets to
// - pins hold their state during sleep
// - master reset resets; other wakes continue
// - pd set at power-up, cleared by sleep
// - only listed peripheral interrupts can wake
// - wake on enabled interrupt, ignoring global enable
// - run next instruction, then vector or inline
// - sleep with pending interrupt is no-op
// - interrupt during sleep: finish sleep, wake
// - oscillator start delay unless external clock
`timescale 1ns/1ps
`default_nettype none

module wsc_watchdog_sleep #(
  parameter int unsigned WDT_BASE_CYCLES = wsc_pkg::WSC_WDT_BASE_CYC,
  parameter int          CW              = 20
) (
  // clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [15:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // pins and configuration
  input  wire logic                  master_reset_pin_n,
  input  wire logic [7:0]            cfg_word,
  // processor core
  input  wire wsc_pkg::wsc_core_in_s core_i,
  output wsc_pkg::wsc_core_out_s     core_o
);
  import wsc_pkg::*;

  // post-scale limit: ratio minus one when assigned, else one base period
  function automatic logic [7:0] wsc_post_limit(input logic [7:0] opt);
    logic [2:0] rate;
    rate = opt[WSC_OPT_RATE_MSB:WSC_OPT_RATE_LSB];
    if (opt[WSC_OPT_ASSIGN_BIT]) begin
      return (8'h01 << rate) - 8'h01;
    end
    return 8'h00;
  endfunction

  // address decode for the error path; reads decode paddr in their own case
  function automatic logic wsc_hit(input logic [15:0] a);
    return (a == WSC_ADR_OPTION) || (a == WSC_ADR_CONFIG) ||
           (a == WSC_ADR_STATUS);
  endfunction

  localparam logic [CW-1:0] BASE_LAST = CW'(WDT_BASE_CYCLES - 1);

  wsc_state_e    state;
  logic [7:0]    opt_reg;
  logic [7:0]    cfg_reg;
  logic          cfg_done_reg;
  logic          to_reg;
  logic          pd_reg;
  logic          vec_reg;
  logic [10:0]   ost_cnt;
  logic [CW-1:0] base_cnt;
  logic [7:0]    post_cnt;
  logic          wdt_to_reg;
  logic          wdt_en;
  logic          ext_clk;
  logic          wdt_hit;
  logic          irq_pend;
  logic          irq_wake;
  logic          sleep_go;
  logic          opt_wr;

  // derived conditions
  // enable only from the latched word
  assign wdt_en   = cfg_done_reg && cfg_reg[WSC_CFG_WDT_EN_BIT];
  assign ext_clk  = cfg_reg[WSC_CFG_OSC_BIT];
  assign wdt_hit  = wdt_to_reg && wdt_en;
  assign irq_pend = |(core_i.irq_flag & core_i.irq_en);
  // sources outside the mask stay asleep
  assign irq_wake = |(core_i.irq_flag & core_i.irq_en & WSC_WAKE_MASK);
  // pending interrupt turns sleep into a no-op
  assign sleep_go = (state == WSC_RUN) && core_i.sleep && !irq_pend &&
                    !wdt_hit && master_reset_pin_n;
  assign opt_wr   = psel && penable && pready && pwrite && pstrb[0] &&
                    (paddr == WSC_ADR_OPTION);

  // configuration word is caught once, after reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg      <= 8'h00;
      cfg_done_reg <= 1'b0;
    end else if (ce && !cfg_done_reg) begin
      cfg_reg      <= cfg_word;
      cfg_done_reg <= 1'b1;
    end
  end

  // option register; any device reset returns it to all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_reg <= WSC_OPT_RESET;
    end else if (ce) begin
      if (core_o.dev_reset) begin
        opt_reg <= WSC_OPT_RESET;
      end else if (opt_wr) begin
        opt_reg <= pwdata[7:0];
      end
    end
  end

  // watchdog: base counter plus post-scaler, free of the core's state
  // counts in run and sleep alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt   <= '0;
      post_cnt   <= 8'h00;
      wdt_to_reg <= 1'b0;
    end else if (ce) begin
      wdt_to_reg <= 1'b0;
      if (!wdt_en) begin
        base_cnt <= '0;
        post_cnt <= 8'h00;
      end else if (core_i.clr_wdt || sleep_go || core_o.dev_reset) begin
        base_cnt <= '0;
        post_cnt <= 8'h00;
      end else if (base_cnt == BASE_LAST) begin
        base_cnt <= '0;
        if (post_cnt >= wsc_post_limit(opt_reg)) begin
          post_cnt   <= 8'h00;
          wdt_to_reg <= 1'b1;
        end else begin
          post_cnt <= post_cnt + 8'h01;
        end
      end else begin
        base_cnt <= base_cnt + CW'(1);
      end
    end
  end

  // sleep/wake sequencer, flags and core controls
  // a counter is used for the start-up delay since the oscillator
  // is modelled as pclk itself; the count is in its periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= WSC_RUN;
      core_o  <= '0;
      to_reg  <= 1'b1;
      pd_reg  <= 1'b1;
      vec_reg <= 1'b0;
      ost_cnt <= 11'h000;
    end else if (ce) begin
      core_o.dev_reset <= 1'b0;
      core_o.resume    <= 1'b0;
      core_o.dummy     <= 1'b0;
      core_o.vector    <= 1'b0;
      if (!master_reset_pin_n) begin
        // master reset returns to run and pulses device reset; to and pd keep their values
        state             <= WSC_RUN;
        core_o.dev_reset  <= 1'b1;
        core_o.osc_off    <= 1'b0;
        core_o.io_hold    <= 1'b0;
        core_o.core_stall <= 1'b0;
        vec_reg           <= 1'b0;
      end else begin
        case (state)
          WSC_RUN: begin
            if (wdt_hit) begin
              core_o.dev_reset <= 1'b1;
              to_reg           <= 1'b0;
            end else if (sleep_go) begin
              pd_reg            <= 1'b0;
              to_reg            <= 1'b1;
              core_o.osc_off    <= 1'b1;
              core_o.io_hold    <= 1'b1;
              core_o.core_stall <= 1'b1;
              state             <= WSC_SLEEP;
            end
          end
          WSC_SLEEP: begin
            // late interrupt seen right after entry
            if (wdt_hit || irq_wake) begin
              if (wdt_hit) begin
                to_reg <= 1'b0;
              end
              // vector only for interrupt with global enable
              vec_reg        <= irq_wake && !wdt_hit && core_i.global_irq_enable;
              core_o.osc_off <= 1'b0;
              ost_cnt        <= 11'h000;
              // no start-up delay on external clock
              state <= ext_clk ? WSC_RESUME : WSC_OST;
            end
          end
          WSC_OST: begin
            if (ost_cnt == WSC_OST_LAST) begin
              state <= WSC_RESUME;
            end else begin
              ost_cnt <= ost_cnt + 11'h001;
            end
          end
          WSC_RESUME: begin
            core_o.core_stall <= 1'b0;
            core_o.io_hold    <= 1'b0;
            core_o.resume     <= 1'b1;
            state <= vec_reg ? WSC_DUMMY1 : WSC_RUN;
          end
          WSC_DUMMY1: begin
            core_o.dummy <= 1'b1;
            state        <= WSC_DUMMY2;
          end
          WSC_DUMMY2: begin
            core_o.dummy <= 1'b1;
            state        <= WSC_VECTOR;
          end
          WSC_VECTOR: begin
            core_o.vector <= 1'b1;
            vec_reg       <= 1'b0;
            state         <= WSC_RUN;
          end
          default: begin
            state <= WSC_RUN;
          end
        endcase
      end
    end
  end

  // apb slave: one wait-free access phase, data caught in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !wsc_hit(paddr);
        case (paddr)
          WSC_ADR_OPTION: prdata <= {24'h000000, opt_reg};
          WSC_ADR_CONFIG: prdata <= {24'h000000, cfg_reg};
          WSC_ADR_STATUS: begin
            prdata <= 32'h0000_0000;
            prdata[WSC_ST_TO_BIT] <= to_reg;
            prdata[WSC_ST_PD_BIT] <= pd_reg;
            prdata[WSC_ST_ASLEEP_BIT] <= (state == WSC_SLEEP);
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks; frozen cycles are not judged
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  property p_sleep_entry;
    sleep_go |=> to_reg && !pd_reg && (state == WSC_SLEEP)
                 && core_o.osc_off;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry flags wrong");

  property p_sleep_nop;
    (state == WSC_RUN) && core_i.sleep && irq_pend && !wdt_hit
      && master_reset_pin_n |=> (state == WSC_RUN) && $stable(pd_reg);
  endproperty
  a_sleep_nop: assert property (p_sleep_nop)
    else $error("sleep with pending irq not a no-op");

  property p_wdt_reset;
    (state == WSC_RUN) && wdt_hit && master_reset_pin_n
      |=> core_o.dev_reset && !to_reg;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("run time-out gave no reset");

  property p_wdt_wake;
    (state == WSC_SLEEP) && wdt_hit && master_reset_pin_n
      |=> (state != WSC_SLEEP) && !to_reg && !core_o.dev_reset;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("sleep time-out did not wake cleanly");

  property p_ost_len;
    (state == WSC_RESUME) && ($past(state) == WSC_OST)
      |-> ($past(ost_cnt) == WSC_OST_LAST) && !ext_clk;
  endproperty
  a_ost_len: assert property (p_ost_len)
    else $error("start-up delay length wrong");

  property p_vector_seq;
    (state == WSC_RESUME) && vec_reg
      |=> ##1 core_o.dummy [*2] ##1 core_o.vector;
  endproperty
  a_vector_seq: assert property (p_vector_seq)
    else $error("vector not after two dummy cycles");

  property p_inline;
    (state == WSC_RESUME) && !vec_reg && master_reset_pin_n
      |=> core_o.resume && (state == WSC_RUN) ##1 !core_o.vector;
  endproperty
  a_inline: assert property (p_inline)
    else $error("in-line wake vectored");

  property p_master_reset_pin;
    !master_reset_pin_n |=> core_o.dev_reset && (state == WSC_RUN);
  endproperty
  a_master_reset_pin: assert property (p_master_reset_pin)
    else $error("master reset not taken");

  property p_hold;
    (state == WSC_SLEEP) |-> core_o.io_hold && core_o.core_stall;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins released during sleep");

  property p_clear;
    core_i.clr_wdt && wdt_en |=> (base_cnt == '0) && (post_cnt == 8'h00);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero watchdog");

  property p_opt_kept;
    core_i.clr_wdt && !opt_wr && !core_o.dev_reset |=> $stable(opt_reg);
  endproperty
  a_opt_kept: assert property (p_opt_kept)
    else $error("clear changed prescaler assignment");

  property p_wdt_off;
    !wdt_en |=> (base_cnt == '0) && !wdt_to_reg;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("disabled watchdog counted");

  property p_irq_wake;
    (state == WSC_SLEEP) && irq_wake && master_reset_pin_n
      |=> (state == WSC_OST) || (state == WSC_RESUME);
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("enabled irq did not wake");

endmodule

`default_nettype wire

//--- tb/wsc_core_model.sv
// core sequencer model that issues clear and sleep instructions
`timescale 1ns/1ps
`default_nettype none

module wsc_core_model (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // bench requests
  input  wire logic                  req_clr,
  input  wire logic                  req_sleep,
  input  wire logic                  gie_i,
  input  wire logic [11:0]           flag_i,
  input  wire logic [11:0]           en_i,
  // block side
  input  wire wsc_pkg::wsc_core_out_s core_o,
  output wsc_pkg::wsc_core_in_s       core_i
);
  import wsc_pkg::*;

  logic clr_reg;
  logic slp_reg;
  logic pend_reg;

  // clear before sleep
  // a stalled core fetches nothing, so no instruction leaves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_reg  <= 1'b0;
      slp_reg  <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      clr_reg  <= (req_clr | req_sleep) & ~core_o.core_stall;
      slp_reg  <= pend_reg & ~core_o.core_stall;
      pend_reg <= req_sleep & ~core_o.core_stall;
    end
  end

  // interrupt levels pass straight through
  assign core_i = '{clr_wdt: clr_reg, sleep: slp_reg, global_irq_enable: gie_i,
                    irq_flag: flag_i, irq_en: en_i};
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// testbench: register access and sleep/watchdog sequences
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wsc_pkg::*;

  localparam int WB = 16;
  localparam int B_RST = 6;
  localparam int B_STALL = 3;
  localparam int B_RES = 2;

  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          mrst_n, rq_c, rq_s, global_irq_enable, er, ce;
  logic [15:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [7:0]    cfg;
  logic [11:0]   flg, ena;
  wsc_core_in_s  ci;
  wsc_core_out_s co;
  int            n_fail, cmp_count, n, k, m;

  // short base period keeps watchdog runs brief
  wsc_watchdog_sleep #(.WDT_BASE_CYCLES(WB), .CW(20)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .master_reset_pin_n(mrst_n), .cfg_word(cfg),
    .core_i(ci), .core_o(co));

  wsc_core_model pm (
    .pclk(pclk), .presetn(presetn), .req_clr(rq_c), .req_sleep(rq_s),
    .gie_i(global_irq_enable), .flag_i(flg), .en_i(ena), .core_o(co), .core_i(ci));

  // clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic inr(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask

  // one transfer; an idle edge follows so psel is never set twice at once
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      n_fail++;
      end_sim();
    end
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_o(input int b, input int lim);
    n = 0;
    while (co[b] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, n, lim);
      end_sim();
    end
  endtask

  task automatic cnt(input int b, input int cyc);
    k = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (co[b] === 1'b1) k++;
    end
  endtask

  task automatic instr(input logic s);
    if (s) rq_s <= 1'b1;
    else rq_c <= 1'b1;
    @(posedge pclk);
    rq_s <= 1'b0;
    rq_c <= 1'b0;
  endtask

  task automatic rst(input logic [7:0] c);
    presetn <= 1'b0;
    cfg <= c;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    cmp_count = 0;
    {psel, penable, pwrite, rq_c, rq_s, global_irq_enable} = 6'h00;
    {paddr, pwdata, flg, ena} = 72'h0;
    presetn = 1'b0;
    mrst_n = 1'b1;
    ce = 1'b1;
    cfg = 8'h05;
    rst(8'h05);
    rdc(WSC_ADR_OPTION, 32'h0000_00FF);
    rdc(WSC_ADR_STATUS, 32'h0000_0018);
    apb(1'b1, WSC_ADR_CONFIG, 32'h0);
    rdc(WSC_ADR_CONFIG, 32'h0000_0005);
    apb(1'b0, 16'h0010, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    instr(1'b0);
    apb(1'b1, WSC_ADR_OPTION, 32'h0);
    wait_o(B_RST, 60);
    inr(n, 4, 24);
    rdc(WSC_ADR_STATUS, 32'h0000_0008);
    rdc(WSC_ADR_OPTION, 32'h0000_00FF);
    apb(1'b1, WSC_ADR_OPTION, 32'h0000_000B);
    instr(1'b0);
    wait_o(B_RST, 300);
    inr(n, 120, 136);
    $display("test running timeout done");
    ena <= 12'h002;
    flg <= 12'h002;
    instr(1'b1);
    cnt(B_STALL, 8);
    chk(k, 0);
    rdc(WSC_ADR_STATUS, 32'h0000_0008);
    flg <= 12'h000;
    $display("test pending sleep done");
    instr(1'b0);
    apb(1'b1, WSC_ADR_OPTION, 32'h0000_0008);
    m = 0;
    repeat (12) begin
      instr(1'b0);
      cnt(B_RST, 6);
      m += k;
    end
    chk(m, 0);
    // frozen clock enable must keep the short watchdog from running out
    ce <= 1'b0;
    cnt(B_RST, 40);
    ce <= 1'b1;
    chk(k, 0);
    rdc(WSC_ADR_OPTION, 32'h0000_0008);
    apb(1'b1, WSC_ADR_OPTION, 32'h0000_000F);
    $display("test clear done");
    // interrupt wake with vectoring, then in line
    for (int g = 1; g >= 0; g--) begin
      global_irq_enable <= g[0];
      instr(1'b1);
      wait_o(B_STALL, 10);
      chk({29'h0, co.io_hold, co.osc_off, co.core_stall}, 32'h7);
      rdc(WSC_ADR_STATUS, 32'h0000_0011);
      flg <= 12'h002;
      wait_o(B_RES, 10);
      @(posedge pclk);
      chk({30'h0, co.dummy, co.vector}, g ? 32'h2 : 32'h0);
      @(posedge pclk);
      chk({30'h0, co.dummy, co.vector}, g ? 32'h2 : 32'h0);
      @(posedge pclk);
      chk({30'h0, co.dummy, co.vector}, g ? 32'h1 : 32'h0);
      flg <= 12'h000;
      rdc(WSC_ADR_STATUS, 32'h0000_0010);
    end
    $display("test interrupt wake done");
    instr(1'b0);
    apb(1'b1, WSC_ADR_OPTION, 32'h0000_0008);
    ena <= 12'h001;
    global_irq_enable <= 1'b0;
    instr(1'b1);
    wait_o(B_STALL, 10);
    flg <= 12'h001;
    wait_o(B_RES, 60);
    inr(n, 6, 40);
    rdc(WSC_ADR_STATUS, 32'h0);
    instr(1'b0);
    apb(1'b1, WSC_ADR_OPTION, 32'h0000_000F);
    flg <= 12'h000;
    ena <= 12'h000;
    $display("test watchdog wake done");
    instr(1'b1);
    wait_o(B_STALL, 10);
    mrst_n <= 1'b0;
    wait_o(B_RST, 5);
    mrst_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, co.core_stall}, 32'h0);
    rdc(WSC_ADR_STATUS, 32'h0000_0010);
    $display("test master reset done");
    rst(8'h00);
    apb(1'b1, WSC_ADR_OPTION, 32'h0);
    cnt(B_RST, 100);
    chk(k, 0);
    ena <= 12'h002;
    instr(1'b1);
    wait_o(B_STALL, 10);
    flg <= 12'h002;
    wait_o(B_RES, 1200);
    inr(n, 1024, 1032);
    $display("test crystal wake done");
    end_sim();
  end
endmodule

`default_nettype wire
